// ### rtl/pscn_top.v
`timescale 1ns/10ps
`default_nettype none
`include "pscn_map.vh"
module pscn_top #(
  parameter FLASH_CYCLES = `PSCN_FLASH_MS * `PSCN_CLK_MHZ * 1000,
  parameter BLINK_CYCLES = 20000000
) (
  input  wire       mclk,
  input  wire       rst,
  input  wire       soft_rst,
  input  wire       program_page,
  input  wire       adc_stb,
  input  wire [7:0] pitch_adc,
  input  wire [7:0] mod_adc,
  input  wire [7:0] slider_adc,
  input  wire [7:0] pedal_adc,
  input  wire [7:0] battery_adc,
  input  wire [7:0] pressure_adc,
  input  wire       sw_pedal1_pin,
  input  wire       sw_pedal2_pin,
  input  wire [1:0] encoder_pin,
  input  wire       spare_input_one,
  input  wire       spare_input_two,
  input  wire       led_diag_strap,
  input  wire       btn_stb,
  input  wire [7:0] btn_code,
  input  wire       btn_is_mode,
  input  wire [2:0] btn_led,
  input  wire       key_stb,
  input  wire [6:0] key_note,
  input  wire       key_upper,
  input  wire       key_lower,
  output reg  [7:0] leds,
  output reg        disp_diag,
  output reg        led_diag,
  output reg        report_stb,
  output reg  [3:0] report_id,
  output reg  [7:0] report_val,
  output reg        key_error,
  output reg        fault_wheel,
  output reg        fault_batt
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  wire [5:0] pins;
  pscn_sync #(.W(6)) u_sync (
    .mclk (mclk),
    .rst  (rst),
    .din  ({spare_input_two, spare_input_one, encoder_pin, sw_pedal2_pin, sw_pedal1_pin}),
    .dout (pins)
  );
  // ----------------------------------------
  // continuous controllers
  // ----------------------------------------
  wire [31:0] ctl_vals;
  wire [3:0]  ctl_chg;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_ctl
      pscn_ctrl u_ctl (
        .mclk       (mclk),
        .rst        (rst),
        .sample_stb (adc_stb),
        .sample     ((gi == 0) ? pitch_adc : (gi == 1) ? mod_adc :
                     (gi == 2) ? slider_adc : pedal_adc),
        .last       (ctl_vals[gi*8 +: 8]),
        .changed    (ctl_chg[gi])
      );
    end
  endgenerate
  // ----------------------------------------
  // power-up state
  // ----------------------------------------
  localparam ST_BOOT  = 3'h0;
  localparam ST_FLASH = 3'h1;
  localparam ST_RUN   = 3'h2;
  localparam ST_SWEEP = 3'h3;
  localparam ST_DIAG  = 3'h4;
  localparam ST_LED   = 3'h5;
  reg [2:0]  state;
  reg [31:0] timer;
  reg [3:0]  flashes;
  reg [2:0]  sweep;
  reg [1:0]  pol;
  reg        strap;
  reg [1:0]  enc_prev;
  reg [1:0]  enc_pos;
  reg [1:0]  ped_last;
  reg [1:0]  spare_last;
  reg [7:0]  press_last;
  reg [7:0]  btn_mask;
  reg [7:0]  blink_led;
  reg [31:0] blink_t;
  reg        held4;
  reg        held5;
  reg        held6;
  reg        held_exit;
  reg        held_enter;
  wire       centred;
  wire       batt_low;
  wire [1:0] ped_act;
  wire [1:0] enc;
  wire       enc_up;
  wire       enc_dn;
  assign centred  = (pitch_adc >= `PSCN_CENTRE_LO) && (pitch_adc <= `PSCN_CENTRE_HI);
  assign batt_low = (battery_adc <= `PSCN_BATT_LOW);
  assign ped_act  = pins[1:0] ^ pol;
  assign enc      = pins[3:2];
  // gray quadrature: 00-01-11-10 clockwise
  assign enc_up = (enc != enc_prev) && (enc == {enc_prev[0], ~enc_prev[1]});
  assign enc_dn = (enc != enc_prev) && (enc == {~enc_prev[0], enc_prev[1]});
  always @(posedge mclk)
  begin
    if (rst || soft_rst)
    begin
      state       <= ST_BOOT;
      timer       <= 32'h0;
      flashes     <= 4'h0;
      sweep       <= 3'h0;
      pol         <= 2'h0;
      strap       <= 1'b0;
      enc_prev    <= 2'h0;
      enc_pos     <= 2'h0;
      ped_last    <= 2'h0;
      spare_last  <= 2'h0;
      press_last  <= 8'h00;
      btn_mask    <= 8'h00;
      blink_led   <= 8'h00;
      blink_t     <= 32'h0;
      held4       <= 1'b0;
      held5       <= 1'b0;
      held6       <= 1'b0;
      held_exit   <= 1'b0;
      held_enter  <= 1'b0;
      leds        <= 8'h00;
      disp_diag   <= 1'b0;
      led_diag    <= 1'b0;
      report_stb  <= 1'b0;
      report_id   <= 4'h0;
      report_val  <= 8'h00;
      key_error   <= 1'b0;
      fault_wheel <= 1'b0;
      fault_batt  <= 1'b0;
    end
    else
    begin
      report_stb <= 1'b0;
      enc_prev   <= enc;
      if (blink_t != 32'h0)
        blink_t <= blink_t - 32'h1;
      else
        blink_led <= 8'h00;
      if (enc_up)
        enc_pos <= enc_pos + 2'h1;
      else if (enc_dn)
        enc_pos <= enc_pos - 2'h1;
      if (btn_stb)
      begin
        held4      <= (btn_code == `PSCN_BTN_4) ? 1'b1 : held4;
        held5      <= (btn_code == `PSCN_BTN_5) ? 1'b1 : held5;
        held6      <= (btn_code == `PSCN_BTN_6) ? 1'b1 : held6;
        held_exit  <= (btn_code == `PSCN_BTN_EXIT) ? 1'b1 : held_exit;
        held_enter <= (btn_code == `PSCN_BTN_ENTER) ? 1'b1 : held_enter;
      end
      case (state)
        ST_BOOT:
        begin
          pol         <= pins[1:0];
          strap       <= led_diag_strap;
          fault_wheel <= ~centred;
          fault_batt  <= batt_low;
          // one flash, one more for the wheel, two more for the battery
          flashes     <= 4'h1 + {3'h0, ~centred} + {2'h0, batt_low, 1'b0};
          timer       <= 32'h0;
          state       <= ST_FLASH;
        end
        ST_FLASH:
        begin
          timer <= timer + 32'h1;
          // synchronisers have settled well before the flash ends
          pol   <= pins[1:0];
          if (timer >= FLASH_CYCLES)
          begin
            timer <= 32'h0;
            if (leds == 8'hFF)
            begin
              leds    <= 8'h00;
              flashes <= flashes - 4'h1;
            end
            else if (flashes != 4'h0)
              leds <= 8'hFF;
            else if (strap)
            begin
              state    <= ST_LED;
              led_diag <= 1'b1;
            end
            else
              state <= ST_RUN;
          end
        end
        ST_RUN:
        begin
          if (held4 && held5 && held6 && program_page)
          begin
            state <= ST_SWEEP;
            sweep <= 3'h7;
            timer <= 32'h0;
          end
          else if (btn_stb && btn_code != `PSCN_BTN_4 && btn_code != `PSCN_BTN_5 &&
                   btn_code != `PSCN_BTN_6)
          begin
            held4 <= 1'b0;
            held5 <= 1'b0;
            held6 <= 1'b0;
          end
        end
        ST_SWEEP:
        begin
          timer <= timer + 32'h1;
          leds  <= 8'h01 << sweep;
          if (timer >= BLINK_CYCLES)
          begin
            timer <= 32'h0;
            if (sweep == 3'h0)
            begin
              state      <= ST_DIAG;
              disp_diag  <= 1'b1;
              leds       <= 8'h00;
              held_exit  <= 1'b0;
              held_enter <= 1'b0;
            end
            else
              sweep <= sweep - 3'h1;
          end
        end
        default:
        begin
          // ST_DIAG and ST_LED share event reporting
          if (state == ST_DIAG && held_exit && held_enter)
          begin
            state     <= ST_BOOT;
            disp_diag <= 1'b0;
          end
          else if (ctl_chg != 4'h0)
          begin
            report_stb <= 1'b1;
            report_id  <= ctl_chg[0] ? `PSCN_ID_PITCH : ctl_chg[1] ? `PSCN_ID_MOD :
                          ctl_chg[2] ? `PSCN_ID_SLIDER : `PSCN_ID_PEDAL;
            report_val <= ctl_chg[0] ? ctl_vals[7:0] : ctl_chg[1] ? ctl_vals[15:8] :
                          ctl_chg[2] ? ctl_vals[23:16] : ctl_vals[31:24];
          end
          else if (ped_act != ped_last)
          begin
            ped_last   <= ped_act;
            report_stb <= 1'b1;
            report_id  <= (ped_act[0] != ped_last[0]) ? `PSCN_ID_SWPED1 : `PSCN_ID_SWPED2;
            report_val <= (ped_act[0] != ped_last[0]) ? {7'h0, ped_act[0]} : {7'h0, ped_act[1]};
            if (ped_act[0] != ped_last[0])
              ped_last[1] <= ped_last[1];
          end
          else if (enc_up || enc_dn)
          begin
            report_stb <= 1'b1;
            report_id  <= `PSCN_ID_KNOB;
            report_val <= {6'h0, enc_up ? enc_pos + 2'h1 : enc_pos - 2'h1};
          end
          else if (pins[5:4] != spare_last)
          begin
            spare_last <= pins[5:4];
            if ((pins[4] & ~spare_last[0]) | (pins[5] & ~spare_last[1]))
            begin
              report_stb <= 1'b1;
              report_id  <= (pins[4] & ~spare_last[0]) ? `PSCN_ID_SPARE1 : `PSCN_ID_SPARE2;
              report_val <= 8'h01;
            end
          end
          else if (btn_stb)
          begin
            report_stb <= 1'b1;
            report_id  <= `PSCN_ID_BUTTON;
            report_val <= btn_code;
            if (btn_is_mode)
            begin
              blink_led <= 8'h80 >> btn_led;
              blink_t   <= BLINK_CYCLES;
            end
          end
          else if (key_stb)
          begin
            report_stb <= 1'b1;
            if (key_lower && !key_upper)
            begin
              key_error  <= 1'b1;
              report_id  <= `PSCN_ID_ERROR;
              report_val <= {1'b0, key_note};
            end
            else
            begin
              key_error  <= 1'b0;
              report_id  <= `PSCN_ID_KEY;
              report_val <= {1'b0, key_note};
            end
          end
          else if (adc_stb && pressure_adc != press_last &&
                   (pressure_adc >= `PSCN_PRESS_MIN || press_last >= `PSCN_PRESS_MIN))
          begin
            press_last <= pressure_adc;
            report_stb <= 1'b1;
            report_id  <= (pressure_adc >= `PSCN_PRESS_MIN) ? `PSCN_ID_PRESSURE : `PSCN_ID_KEY;
            report_val <= (pressure_adc >= `PSCN_PRESS_MIN) ? pressure_adc : {1'b0, key_note};
          end
          if (state == ST_LED)
          begin
            // binary readout, program LED is bit 7
            if (report_stb)
              leds <= (report_id == `PSCN_ID_SWPED1 && report_val[0]) ? `PSCN_SWPED1_LED :
                      (report_id == `PSCN_ID_SWPED2 && report_val[0]) ? `PSCN_SWPED2_LED :
                      (report_id == `PSCN_ID_KNOB) ? (8'h01 << report_val[1:0]) :
                      report_val;
            else if (key_error)
              leds <= blink_t[22] ? 8'hFF : 8'h00;
          end
          else
            leds <= blink_led;
        end
      endcase
      // a fresh boot forgets every half-made button chord
      if (state == ST_BOOT)
      begin
        held4      <= 1'b0;
        held5      <= 1'b0;
        held6      <= 1'b0;
        held_exit  <= 1'b0;
        held_enter <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ### rtl/pscn_map.vh
`ifndef PSCN_MAP_VH
`define PSCN_MAP_VH
`define PSCN_CLK_MHZ       200
`define PSCN_FLASH_MS      1000
`define PSCN_CENTRE_LO     8'h78
`define PSCN_CENTRE_HI     8'h88
`define PSCN_BATT_LOW      8'h20
`define PSCN_PRESS_MIN     8'h04
`define PSCN_WHEEL_STEP    8'h02
`define PSCN_BTN_4         8'h33
`define PSCN_BTN_5         8'h32
`define PSCN_BTN_6         8'h31
`define PSCN_BTN_EXIT      8'h73
`define PSCN_BTN_ENTER     8'h53
`define PSCN_ID_PITCH      4'h1
`define PSCN_ID_MOD        4'h2
`define PSCN_ID_SLIDER     4'h3
`define PSCN_ID_PEDAL      4'h4
`define PSCN_ID_SWPED1     4'h5
`define PSCN_ID_SWPED2     4'h6
`define PSCN_ID_KNOB       4'h7
`define PSCN_ID_BUTTON     4'h8
`define PSCN_ID_KEY        4'h9
`define PSCN_ID_PRESSURE   4'hA
`define PSCN_ID_SPARE1     4'hB
`define PSCN_ID_SPARE2     4'hC
`define PSCN_ID_ERROR      4'hD
`define PSCN_SWPED1_LED    8'hF1
`define PSCN_SWPED2_LED    8'hF8
`endif

// ### rtl/pscn_sync.v
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// three-stage pin synchroniser, change when stages two and three agree
// ----------------------------------------
module pscn_sync #(
  parameter W = 1
) (
  input  wire         mclk,
  input  wire         rst,
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);
  reg [W-1:0] s1;
  reg [W-1:0] s2;
  reg [W-1:0] s3;
  genvar i;
  always @(posedge mclk)
  begin
    if (rst)
    begin
      s1 <= {W{1'b0}};
      s2 <= {W{1'b0}};
      s3 <= {W{1'b0}};
    end
    else
    begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
    end
  end
  generate
    for (i = 0; i < W; i = i + 1)
    begin : g_bit
      always @(posedge mclk)
      begin
        if (rst)
          dout[i] <= 1'b0;
        else if (s2[i] == s3[i])
          dout[i] <= s3[i];
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ### rtl/pscn_ctrl.v
`timescale 1ns/10ps
`default_nettype none
`include "pscn_map.vh"
// ----------------------------------------
// continuous controller: report on change of two or more counts
// ----------------------------------------
module pscn_ctrl (
  input  wire       mclk,
  input  wire       rst,
  input  wire       sample_stb,
  input  wire [7:0] sample,
  output reg  [7:0] last,
  output reg        changed
);
  wire [7:0] diff;
  assign diff = (sample > last) ? (sample - last) : (last - sample);
  always @(posedge mclk)
  begin
    if (rst)
    begin
      last    <= 8'h00;
      changed <= 1'b0;
    end
    else
    begin
      changed <= 1'b0;
      // ends of travel still reach 0 and 255
      if (sample_stb && (diff >= `PSCN_WHEEL_STEP ||
          (diff != 8'h00 && (sample == 8'h00 || sample == 8'hFF))))
      begin
        last    <= sample;
        changed <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/pscn_host.sv
`timescale 1ns/10ps
`default_nettype none
// ----
// host side: latches every scanned event
// ----
module pscn_host (
  input  wire logic        mclk,
  input  wire logic        report_stb,
  input  wire logic [3:0]  report_id,
  input  wire logic [7:0]  report_val,
  output var  logic [3:0]  got_id,
  output var  logic [7:0]  got_val,
  output var  logic [15:0] n_ev
);
  initial n_ev = 16'h0000;
  always @(posedge mclk)
    if (report_stb)
    begin
      got_id  <= report_id;
      got_val <= report_val;
      n_ev    <= n_ev + 16'h0001;
    end
endmodule
`default_nettype wire

// ### tb/pscn_top_sva.sv
`timescale 1ns/10ps
`default_nettype none
// ----
// port checker
// ----
module pscn_top_sva #(
  parameter FLASH_CYCLES = 20,
  parameter BLINK_CYCLES = 10
) (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       soft_rst,
  input wire logic       adc_stb,
  input wire logic       report_stb,
  input wire logic [3:0] report_id,
  input wire logic [7:0] report_val,
  input wire logic       key_error,
  input wire logic       disp_diag,
  input wire logic       led_diag,
  input wire logic [7:0] leds
);
  logic [7:0] lastp;
  logic       seen;
  wire  [7:0] dp;
  // distance from the last pitch report
  assign dp = (report_val > lastp) ? report_val - lastp : lastp - report_val;
  always @(posedge mclk)
    if (rst || soft_rst)
    begin
      seen  <= 1'b0;
      lastp <= 8'h00;
    end
    else if (report_stb && report_id == 4'h1)
    begin
      seen  <= 1'b1;
      lastp <= report_val;
    end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  a_pitch_latency: assert property (report_stb && report_id == 4'h1 |-> $past(adc_stb, 2))
    else $error("pitch report not two cycles after sample strobe");
  a_pitch_step: assert property (report_stb && report_id == 4'h1 && seen
    |-> dp >= 8'h02 || report_val == 8'h00 || report_val == 8'hFF)
    else $error("pitch report step below two");
  a_diag_only: assert property (report_stb |-> disp_diag || led_diag || $past(disp_diag))
    else $error("event reported outside diagnostics");
  a_mode_excl: assert property (!(disp_diag && led_diag))
    else $error("both diagnostic modes active");
  a_led_hold: assert property (led_diag && !soft_rst |=> led_diag)
    else $error("led diagnostic left without reset");
  a_press_min: assert property (report_stb && report_id == 4'hA |-> report_val >= 8'h04)
    else $error("pressure report below four");
  a_knob_range: assert property (report_stb && report_id == 4'h7 |-> report_val <= 8'h03)
    else $error("knob position wider than two bits");
  a_key_err: assert property (report_stb && report_id == 4'hD |-> ##[0:1] key_error)
    else $error("error report without error flag");
  a_soft_quiet: assert property (soft_rst |=> !disp_diag && !led_diag && !report_stb
    && leds == 8'h00)
    else $error("soft reset left outputs active");
endmodule
bind pscn_top pscn_top_sva #(.FLASH_CYCLES(FLASH_CYCLES), .BLINK_CYCLES(BLINK_CYCLES)) u_sva (
  .mclk(mclk), .rst(rst), .soft_rst(soft_rst), .adc_stb(adc_stb), .report_stb(report_stb),
  .report_id(report_id), .report_val(report_val), .key_error(key_error),
  .disp_diag(disp_diag), .led_diag(led_diag), .leds(leds));
`default_nettype wire

// ### tb/panel_scanner_diagnostics_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "pscn_map.vh"
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
`define WAITC(c, n) begin wi = 0; while (!(c) && wi < n) begin tick; wi++; end \
  if (!(c)) hang; end
module panel_scanner_diagnostics_test;
  logic       mclk = 0, rst = 1, soft_rst = 0, program_page = 0, adc_stb = 0;
  logic [7:0] pitch_adc = 8'h80, mod_adc = 0, slider_adc = 0, pedal_adc = 0;
  logic [7:0] battery_adc = 8'h30, pressure_adc = 0, btn_code = 0;
  logic       sw_pedal1_pin = 0, sw_pedal2_pin = 0, spare_input_one = 0, spare_input_two = 0;
  logic [1:0] encoder_pin = 0;
  logic       led_diag_strap = 0, btn_stb = 0, btn_is_mode = 0, key_stb = 0;
  logic [2:0] btn_led = 0;
  logic [6:0] key_note = 0;
  logic       key_upper = 0, key_lower = 0;
  logic [7:0] leds, report_val, got_val;
  logic [3:0] report_id, got_id;
  logic       disp_diag, led_diag, report_stb, key_error, fault_wheel, fault_batt;
  logic [15:0] n_ev, base;
  int         mismatches = 0, n_checks = 0, wi;
  pscn_top #(.FLASH_CYCLES(20), .BLINK_CYCLES(10)) DUT (.mclk, .rst, .soft_rst, .program_page,
    .adc_stb, .pitch_adc, .mod_adc, .slider_adc, .pedal_adc, .battery_adc, .pressure_adc,
    .sw_pedal1_pin, .sw_pedal2_pin, .encoder_pin, .spare_input_one, .spare_input_two,
    .led_diag_strap, .btn_stb, .btn_code, .btn_is_mode, .btn_led, .key_stb, .key_note,
    .key_upper, .key_lower, .leds, .disp_diag, .led_diag, .report_stb, .report_id,
    .report_val, .key_error, .fault_wheel, .fault_batt);
  pscn_host HOST (.mclk, .report_stb, .report_id, .report_val, .got_id, .got_val, .n_ev);
  initial
  begin
    forever #2.5 mclk = ~mclk;
  end
  task conclude;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task tick; @(posedge mclk); #1; endtask
  task hang; mismatches++; conclude; endtask
  task rep; `WAITC(n_ev != base, 40) base = n_ev; endtask
  task pulse_adc; adc_stb = 1; tick; adc_stb = 0; tick; endtask
  task reset_dut; rst = 1; repeat (2) tick; rst = 0; endtask
  task press(input [7:0] c, input m, input [2:0] l);
    btn_code = c; btn_is_mode = m; btn_led = l; btn_stb = 1; tick; btn_stb = 0; tick;
  endtask
  task key(input [6:0] n, input u, input d);
    key_note = n; key_upper = u; key_lower = d; key_stb = 1; tick; key_stb = 0; tick;
  endtask
  // ----
  // scenarios
  // ----
  task boot_case(input [7:0] p, input [7:0] b, input int n);
    int f;
    logic pv;
    pitch_adc = p; battery_adc = b; reset_dut; f = 0; pv = 0;
    repeat (400)
    begin
      tick; if (leds === 8'hFF && !pv) f++; pv = (leds === 8'hFF);
    end
    `CHK("flashes", n, f)
    `CHK("faults", {n == 2 || n == 4, n > 2}, {fault_wheel, fault_batt})
  endtask
  task enter_diag;
    program_page = 1; press(`PSCN_BTN_4, 0, 0); press(`PSCN_BTN_5, 0, 0); press(`PSCN_BTN_6, 0, 0);
    `WAITC(disp_diag === 1'b1, 300)
    `CHK("sweep", 1'b1, wi >= 75)
  endtask
  task ctrl_scn;
    pulse_adc; repeat (20) tick; base = n_ev;
    pitch_adc = 8'h81; pulse_adc; repeat (20) tick;
    `CHK("quiet", base, n_ev)
    pitch_adc = 8'h82; pulse_adc; rep;
    `CHK("pitch", {`PSCN_ID_PITCH, 8'h82}, {got_id, got_val})
    mod_adc = 8'hFF; pulse_adc; rep;
    `CHK("mod", {`PSCN_ID_MOD, 8'hFF}, {got_id, got_val})
  endtask
  task key_scn;
    key(7'h3C, 1, 0); rep;
    `CHK("upper", {`PSCN_ID_KEY, 8'h3C}, {got_id, got_val})
    key(7'h3C, 1, 1); rep;
    `CHK("lower", {`PSCN_ID_KEY, 8'h3C}, {got_id, got_val})
    pressure_adc = 8'h04; pulse_adc; rep;
    `CHK("press", {`PSCN_ID_PRESSURE, 8'h04}, {got_id, got_val})
    pressure_adc = 8'h02; pulse_adc; rep;
    `CHK("revert", {`PSCN_ID_KEY, 8'h3C}, {got_id, got_val})
    key(7'h40, 0, 1); rep;
    `CHK("err", {`PSCN_ID_ERROR, 1'b1}, {got_id, key_error})
  endtask
  task pins_scn;
    logic [1:0] g [4];
    g = '{2'b00, 2'b01, 2'b11, 2'b10};
    spare_input_one = 1; rep;
    `CHK("spare1", `PSCN_ID_SPARE1, got_id)
    spare_input_two = 1; rep;
    `CHK("spare2", `PSCN_ID_SPARE2, got_id)
    sw_pedal1_pin = 1; rep;
    `CHK("pedal", `PSCN_ID_SWPED1, got_id)
    for (int k = 1; k <= 4; k++)
    begin
      encoder_pin = g[k % 4]; rep;
      `CHK("cw", {`PSCN_ID_KNOB, 8'(k % 4)}, {got_id, got_val})
    end
    encoder_pin = 2'b10; rep;
    `CHK("ccw", {`PSCN_ID_KNOB, 8'h03}, {got_id, got_val})
  endtask
  task btn_scn;
    press(8'h14, 1, 0); rep;
    `CHK("button", {`PSCN_ID_BUTTON, 8'h14}, {got_id, got_val})
    `WAITC(leds[7] === 1'b1, 60)
    `CHK("mode_led", 1'b1, leds[7])
    press(`PSCN_BTN_EXIT, 0, 0); press(`PSCN_BTN_ENTER, 0, 0);
    `WAITC(disp_diag === 1'b0, 40)
    `CHK("exit", 1'b0, disp_diag)
  endtask
  task led_scn;
    led_diag_strap = 1; mod_adc = 0; reset_dut;
    `WAITC(led_diag === 1'b1, 500)
    `CHK("led_mode", 1'b0, disp_diag)
    pitch_adc = 8'hA7; pulse_adc;
    `WAITC(leds === 8'hA7, 100)
    `CHK("readout", 8'hA7, leds)
    soft_rst = 1; tick; soft_rst = 0;
    `CHK("soft", 1'b0, led_diag)
    tick;
    `CHK("soft_leds", 8'h00, leds)
  endtask
  initial
  begin
    boot_case(8'h88, 8'h21, 1);
    boot_case(8'h77, 8'h21, 2);
    boot_case(8'h78, 8'h20, 3);
    boot_case(8'h89, 8'h20, 4);
    boot_case(8'h80, 8'h30, 1);
    enter_diag;
    ctrl_scn;
    key_scn;
    pins_scn;
    btn_scn;
    led_scn;
    conclude;
  end
endmodule
`default_nettype wire
